// >>> core/ext_crtc_pkg.sv
// Shared constants and carrier types for the extended CRT-controller register bank
package ext_crtc_pkg;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_BKWD3 = 8'h34;
  localparam logic [7:0] IDX_TIMING_LOCK = 8'h35;
  localparam logic [7:0] IDX_STRAP_LO = 8'h36;
  localparam logic [7:0] IDX_STRAP_HI = 8'h37;
  localparam logic [7:0] IDX_EXT_KEY = 8'h38;
  localparam logic [7:0] IDX_SYS_KEY = 8'h39;
  localparam logic [7:0] IDX_MISC_MEM = 8'h3a;
  localparam logic [7:0] IDX_XFER_POS = 8'h3b;
  localparam logic [7:0] IDX_IL_OFS = 8'h3c;
  localparam logic [7:0] IDX_BUS_CFG = 8'h40;
  localparam logic [7:0] IDX_FW_SCRATCH = 8'h41;
  localparam logic [7:0] IDX_PCLK_MODE = 8'h42;
  localparam logic [7:0] IDX_EXT_FIRST = 8'h30;
  localparam logic [7:0] IDX_EXT_LAST = 8'h3f;
  localparam logic [7:0] IDX_SYS_FIRST = 8'h40;
  localparam logic [7:0] IDX_SYS_LAST = 8'h5f;
  localparam logic [7:0] IDX_VRE = 8'h11;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_BUS_CFG = 8'ha4;
  localparam logic [15:0] RST_STRAP = 16'h0000;

  // ----------------------------------------------------------------
  // Unlock keys
  // ----------------------------------------------------------------
  localparam logic [7:0] EXT_KEY_MASK = 8'hcc;
  localparam logic [7:0] EXT_KEY_VAL = 8'h48;
  localparam logic [7:0] SYS_KEY_MASK = 8'he0;
  localparam logic [7:0] SYS_KEY_VAL = 8'ha0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int LK_VTMG = 4;
  localparam int LK_HTMG = 5;
  localparam int VRE_PROTECT = 7;
  localparam int MM_ALT_EN = 2;
  localparam int MM_TOP = 3;
  localparam int MM_ENH = 4;
  localparam int MM_WIDE = 7;
  localparam int BK3_XFER_EN = 4;
  localparam int BC_ENH_ACC = 0;
  localparam int BC_PIN_SEL = 1;
  localparam int BC_WAIT1 = 2;
  localparam int BC_POST = 3;
  localparam int PM_INTL = 5;
  localparam int ST_ROM_ALL = 3;
  localparam int ST_SETUP = 8;
  localparam int ST_NOWAIT = 11;
  localparam int ST_M16_DAC = 12;

  // ----------------------------------------------------------------
  // Protected bit sets of the standard timing registers
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_ALL = 8'hff;
  localparam logic [7:0] MASK_OVF = 8'had;
  localparam logic [7:0] MASK_MSL = 8'h20;
  localparam logic [7:0] MASK_VRE = 8'h0f;
  localparam logic [7:0] MASK_MODE = 8'h04;

  // ----------------------------------------------------------------
  // ROM window and external clock select
  // ----------------------------------------------------------------
  localparam logic [4:0] ROM_WIN_HI = 5'h18;
  localparam logic [8:0] ROM_HOLE_HI = 9'h18c;
  localparam logic [1:0] CLK_SEL_EXT = 2'b11;

  typedef enum logic [1:0] {
    BUS_EISA = 2'b00,
    BUS_LOCAL = 2'b01,
    BUS_RSVD = 2'b10,
    BUS_ISA = 2'b11
  } bus_type_t;

  typedef struct packed {
    logic index_wr;
    logic data_wr;
    logic data_rd;
    logic [7:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic wr;
    logic [7:0] index;
    logic [7:0] data;
    logic [7:0] keep_mask;
  } std_wr_t;

endpackage

// >>> core/clock_synth_strobe.sv
// Strobes the dot-clock select code out to the external clock synthesizer
`timescale 1ns/1ns
module clock_synth_strobe (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [1:0] clock_sel,
  input wire logic [3:0] dot_select,
  input wire logic dot_written,
  output logic clock_strobe_write,
  output logic [3:0] synth_code
);
  import ext_crtc_pkg::*;

  typedef struct packed {
    logic [1:0] prev_sel;
    logic strobe;
    logic [3:0] code;
  } strobe_state_t;

  strobe_state_t st_ff;
  strobe_state_t nxt_st;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.prev_sel = clock_sel;
    nxt_st.strobe = 1'b0;
    // Resend on entry to the external select so the synthesizer never lags
    if (clock_sel == CLK_SEL_EXT && (dot_written || st_ff.prev_sel != CLK_SEL_EXT)) begin
      nxt_st.strobe = 1'b1;
      nxt_st.code = dot_select;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign clock_strobe_write = st_ff.strobe;
  assign synth_code = st_ff.code;
endmodule // clock_synth_strobe

// >>> core/ext_crtc_lock_config_regs.sv
// Extended CRT-controller lock, strap and configuration register bank
//
// Overview of operation
// - Base field, in 16 KByte units, is added to host address bits 17-14.
// - Vertical lock blocks writes to listed vertical timing registers and bit subsets.
// - Horizontal lock blocks writes to indices 00-05 and index 17 bit 2.
// - Retrace-end bit 7 also locks indices 00-07 of those, but not 09, 10, 11, 15, 16 or 17.
// - Two read-only registers capture the sixteen strap pins at reset.
// - ISA strap bit 3 low excludes C6000H-C67FFH from the ROM decode.
// - Strap bit 8 picks setup bit on ISA, device enable on local bus.
// - Strap bit 11 enables zero-wait on ISA, tri-state access ack on local.
// - Strap bit 12 selects 16-bit select source, or when low suppresses DAC access acks.
// - Key 01xx10xx in first lock register opens the extended register set.
// - Key 101xxxxx in second lock register opens system control registers.
// - Locked after reset; unlocked until a significant key bit changes.
// - Reserved bits are written as zero; reads of them are undefined.
// - Alternate refresh count is used only while its enable bit is set.
// - Top-of-memory bit forces host and CRTC accesses into top memory.
// - Enhanced-color bit configures shift registers for 4-bit or wide modes.
// - Bus-width bit selects 8-bit bus, or 16-bit with 16-bit select.
// - Transfer cycle is issued at the programmed horizontal character position.
// - Interlace retrace offset in character clocks applies in interlaced mode.
// - Config bit 0 enables enhanced access; bit 1 repurposes monitor-ID pins.
// - Wait-state bit inserts one wait state; another bit enables posting.
// - Local-bus wait fields map 0,1,3,2; ISA read-wait 00 allows zero-wait.
// - Dot-clock field strobes to synthesizer only with clock select 11.
// - Transfer-position enable picks horizontal total or programmed position.
`timescale 1ns/1ns
module ext_crtc_lock_config_regs (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire ext_crtc_pkg::host_req_t host_req,
  output logic [7:0] host_rdata,
  output logic host_rvalid,
  input wire logic [15:0] pixel_data_strap_pins,
  input wire logic [19:0] host_addr,
  input wire logic dac_access,
  input wire logic [1:0] misc_clock_sel,
  input wire logic [7:0] h_total_pos,
  input wire logic [7:0] h_char_count,
  input wire logic dac_ctl_strobe_mode,
  input wire logic strobe_read_req_n,
  input wire logic bus_request_req_n,
  input wire logic monitor_id_pin0_i,
  output logic monitor_id_pin0_o,
  output logic monitor_id_pin0_oe,
  input wire logic monitor_id_pin1_i,
  output logic monitor_id_pin1_o,
  output logic monitor_id_pin1_oe,
  output ext_crtc_pkg::std_wr_t std_wr,
  output logic [3:0] display_addr_hi,
  output logic rom_chip_select,
  output logic setup_bit_is_bit4,
  output logic device_enable,
  output logic zero_wait_out,
  output logic local_access_tristate,
  output logic local_access_ack_en,
  output logic local_ready_en,
  output logic mem16_select_out,
  output logic wide_bus_enable,
  output logic [1:0] alt_refresh_count,
  output logic alt_refresh_enable,
  output logic top_of_memory,
  output logic enhanced_color_shift,
  output logic transfer_cycle_pulse,
  output logic [7:0] interlace_offset,
  output logic interlace_active,
  output logic enhanced_access_en,
  output logic [1:0] monitor_id,
  output logic bus_grant_in,
  output logic wait_state_control,
  output logic write_posting_enable,
  output logic [1:0] decode_wait_states,
  output logic [1:0] read_wait_states,
  output logic clock_strobe_write,
  output logic [3:0] synth_code
);
  import ext_crtc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] index;
    logic strap_done;
    logic [15:0] strap;
    logic [7:0] timing_lock;
    logic [7:0] bkwd3;
    logic [7:0] ext_key;
    logic [7:0] sys_key;
    logic [7:0] misc_mem;
    logic [7:0] xfer_pos;
    logic [7:0] il_ofs;
    logic [7:0] bus_cfg;
    logic [7:0] fw_scratch;
    logic [7:0] pclk_mode;
    logic [7:0] vre_shadow;
    logic [7:0] rdata;
    logic rvalid;
    std_wr_t std;
    logic [3:0] addr_hi;
    logic xfer_pulse;
    logic [1:0] mon_id;
    logic grant;
  } bank_state_t;

  bank_state_t st_ff;
  bank_state_t nxt_st;

  logic ext_open;
  logic sys_open;
  logic in_ext;
  logic in_sys;
  logic access_ok;
  logic dot_written;
  bus_type_t bus_type;
  logic [7:0] xfer_target;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [1:0] wait_map(input logic [1:0] code);
    case (code)
      2'b00: wait_map = 2'd0;
      2'b01: wait_map = 2'd1;
      2'b10: wait_map = 2'd3;
      2'b11: wait_map = 2'd2;
      default: wait_map = 2'd0;
    endcase
  endfunction

  // Bits of a standard timing register that a write must leave alone
  function automatic logic [7:0] prot_mask(input logic [7:0] idx, input logic vlock,
                                           input logic hlock, input logic vre);
    logic hv;
    logic vv;
    hv = hlock | vre;
    vv = vlock | vre;
    case (idx)
      8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05:
        prot_mask = hv ? MASK_ALL : 8'h00;
      8'h06: prot_mask = vv ? MASK_ALL : 8'h00;
      8'h07: prot_mask = vv ? MASK_OVF : 8'h00;
      8'h09: prot_mask = vlock ? MASK_MSL : 8'h00;
      8'h10, 8'h15, 8'h16: prot_mask = vlock ? MASK_ALL : 8'h00;
      8'h11: prot_mask = vlock ? MASK_VRE : 8'h00;
      8'h17: prot_mask = hlock ? MASK_MODE : 8'h00;
      default: prot_mask = 8'h00;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Access gating
  // ----------------------------------------------------------------
  // Keys are compared live, so any change of a significant bit relocks at once
  assign ext_open = (st_ff.ext_key & EXT_KEY_MASK) == EXT_KEY_VAL;
  assign sys_open = (st_ff.sys_key & SYS_KEY_MASK) == SYS_KEY_VAL;
  assign in_ext = st_ff.index >= IDX_EXT_FIRST && st_ff.index <= IDX_EXT_LAST;
  assign in_sys = st_ff.index >= IDX_SYS_FIRST && st_ff.index <= IDX_SYS_LAST;
  // The key registers themselves stay reachable, or nothing could unlock
  always_comb begin
    if (st_ff.index == IDX_EXT_KEY || st_ff.index == IDX_SYS_KEY) begin
      access_ok = 1'b1;
    end else if (in_ext) begin
      access_ok = ext_open;
    end else if (in_sys) begin
      access_ok = sys_open;
    end else begin
      access_ok = 1'b1;
    end
  end

  assign bus_type = bus_type_t'(st_ff.strap[1:0]);
  assign dot_written = host_req.data_wr && access_ok && st_ff.index == IDX_PCLK_MODE;

  // Horizontal total stands in when programmed position is disabled
  assign xfer_target = st_ff.bkwd3[BK3_XFER_EN] ? st_ff.xfer_pos : h_total_pos;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rvalid = 1'b0;
    nxt_st.std.wr = 1'b0;

    // Straps are caught at the first edge after reset release
    if (!st_ff.strap_done) begin
      nxt_st.strap = pixel_data_strap_pins;
      nxt_st.strap_done = 1'b1;
    end

    if (host_req.index_wr) begin
      nxt_st.index = host_req.wdata;
    end

    if (host_req.data_wr) begin
      if (st_ff.index < IDX_EXT_FIRST) begin
        // Standard registers live elsewhere; forward with the keep mask
        nxt_st.std.wr = 1'b1;
        nxt_st.std.index = st_ff.index;
        nxt_st.std.data = host_req.wdata;
        nxt_st.std.keep_mask = prot_mask(st_ff.index, st_ff.timing_lock[LK_VTMG],
                                         st_ff.timing_lock[LK_HTMG],
                                         st_ff.vre_shadow[VRE_PROTECT]);
        // Shadow retrace-end so its protect bit is known here
        if (st_ff.index == IDX_VRE) begin
          nxt_st.vre_shadow = (host_req.wdata & ~nxt_st.std.keep_mask) |
                              (st_ff.vre_shadow & nxt_st.std.keep_mask);
        end
      end else if (access_ok) begin
        case (st_ff.index)
          IDX_BKWD3: nxt_st.bkwd3 = host_req.wdata;
          IDX_TIMING_LOCK: nxt_st.timing_lock = host_req.wdata;
          IDX_EXT_KEY: nxt_st.ext_key = host_req.wdata;
          IDX_SYS_KEY: nxt_st.sys_key = host_req.wdata;
          IDX_MISC_MEM: nxt_st.misc_mem = host_req.wdata;
          IDX_XFER_POS: nxt_st.xfer_pos = host_req.wdata;
          IDX_IL_OFS: nxt_st.il_ofs = host_req.wdata;
          IDX_BUS_CFG: nxt_st.bus_cfg = host_req.wdata;
          IDX_FW_SCRATCH: nxt_st.fw_scratch = host_req.wdata;
          IDX_PCLK_MODE: nxt_st.pclk_mode = host_req.wdata;
          default: nxt_st.index = st_ff.index;
        endcase
      end
      // Writes to a locked index are dropped with no error
    end

    if (host_req.data_rd) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = 8'h00;
      if (access_ok) begin
        // Reserved bits read back as stored; software must not rely on them
        case (st_ff.index)
          IDX_BKWD3: nxt_st.rdata = st_ff.bkwd3;
          IDX_TIMING_LOCK: nxt_st.rdata = st_ff.timing_lock;
          IDX_STRAP_LO: nxt_st.rdata = st_ff.strap[7:0];
          IDX_STRAP_HI: nxt_st.rdata = st_ff.strap[15:8];
          IDX_EXT_KEY: nxt_st.rdata = st_ff.ext_key;
          IDX_SYS_KEY: nxt_st.rdata = st_ff.sys_key;
          IDX_MISC_MEM: nxt_st.rdata = st_ff.misc_mem;
          IDX_XFER_POS: nxt_st.rdata = st_ff.xfer_pos;
          IDX_IL_OFS: nxt_st.rdata = st_ff.il_ofs;
          IDX_BUS_CFG: nxt_st.rdata = st_ff.bus_cfg;
          IDX_FW_SCRATCH: nxt_st.rdata = st_ff.fw_scratch;
          IDX_PCLK_MODE: nxt_st.rdata = st_ff.pclk_mode;
          IDX_VRE: nxt_st.rdata = st_ff.vre_shadow;
          default: nxt_st.rdata = 8'h00;
        endcase
      end
    end

    // Display address: base offset added to host bits 17-14, modulo 16
    nxt_st.addr_hi = 4'(st_ff.timing_lock[3:0] + host_addr[17:14]);

    nxt_st.xfer_pulse = h_char_count == xfer_target;

    // Monitor-ID pins are sampled only while they keep their normal role
    if (!st_ff.bus_cfg[BC_PIN_SEL]) begin
      nxt_st.mon_id = {monitor_id_pin1_i, monitor_id_pin0_i};
    end
    nxt_st.grant = st_ff.bus_cfg[BC_PIN_SEL] && !dac_ctl_strobe_mode
                   && !monitor_id_pin0_i;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.strap <= RST_STRAP;
      st_ff.timing_lock <= RST_ZERO;
      st_ff.ext_key <= RST_ZERO;
      st_ff.sys_key <= RST_ZERO;
      st_ff.bus_cfg <= RST_BUS_CFG;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Strap-driven bus behaviour
  // ----------------------------------------------------------------
  // ROM window C0000H-C7FFFH, with the C6000H-C67FFH hole unless strapped open
  always_comb begin
    rom_chip_select = 1'b0;
    if (bus_type == BUS_ISA && host_addr[19:15] == ROM_WIN_HI) begin
      rom_chip_select = st_ff.strap[ST_ROM_ALL] ||
                        host_addr[19:11] != ROM_HOLE_HI;
    end
  end

  assign setup_bit_is_bit4 = st_ff.strap[ST_SETUP];
  assign device_enable = (bus_type != BUS_LOCAL) || st_ff.strap[ST_SETUP];
  assign zero_wait_out = bus_type == BUS_ISA && st_ff.strap[ST_NOWAIT] &&
                         st_ff.bus_cfg[7:6] == 2'b00;
  assign local_access_tristate = bus_type == BUS_LOCAL && st_ff.strap[ST_NOWAIT];
  assign local_access_ack_en = !(bus_type == BUS_LOCAL && dac_access &&
                                 !st_ff.strap[ST_M16_DAC]);
  assign local_ready_en = local_access_ack_en;
  // Without the strap an external decoder owns the 16-bit select
  assign mem16_select_out = bus_type == BUS_ISA && st_ff.strap[ST_M16_DAC] &&
                            st_ff.misc_mem[MM_WIDE];

  // ----------------------------------------------------------------
  // Memory, refresh and display controls
  // ----------------------------------------------------------------
  assign display_addr_hi = st_ff.addr_hi;
  assign wide_bus_enable = st_ff.misc_mem[MM_WIDE];
  assign alt_refresh_enable = st_ff.misc_mem[MM_ALT_EN];
  assign alt_refresh_count = st_ff.misc_mem[MM_ALT_EN] ? st_ff.misc_mem[1:0]
                                                       : 2'b00;
  assign top_of_memory = st_ff.misc_mem[MM_TOP];
  assign enhanced_color_shift = st_ff.misc_mem[MM_ENH];
  assign transfer_cycle_pulse = st_ff.xfer_pulse;
  assign interlace_active = st_ff.pclk_mode[PM_INTL];
  assign interlace_offset = st_ff.pclk_mode[PM_INTL] ? st_ff.il_ofs : 8'h00;

  // ----------------------------------------------------------------
  // Host bus configuration
  // ----------------------------------------------------------------
  assign enhanced_access_en = st_ff.bus_cfg[BC_ENH_ACC];
  assign wait_state_control = st_ff.bus_cfg[BC_WAIT1];
  assign write_posting_enable = st_ff.bus_cfg[BC_POST];
  assign decode_wait_states = wait_map(st_ff.bus_cfg[5:4]);
  assign read_wait_states = wait_map(st_ff.bus_cfg[7:6]);
  assign monitor_id = st_ff.mon_id;
  assign bus_grant_in = st_ff.grant;

  // Pin 0 drives the read strobe in strobe mode; pin 1 drives bus request outside it
  assign monitor_id_pin0_oe = st_ff.bus_cfg[BC_PIN_SEL] && dac_ctl_strobe_mode;
  assign monitor_id_pin0_o = strobe_read_req_n;
  assign monitor_id_pin1_oe = st_ff.bus_cfg[BC_PIN_SEL] && !dac_ctl_strobe_mode;
  assign monitor_id_pin1_o = bus_request_req_n;

  assign host_rdata = st_ff.rdata;
  assign host_rvalid = st_ff.rvalid;
  assign std_wr = st_ff.std;

  // ----------------------------------------------------------------
  // Dot clock strobe
  // ----------------------------------------------------------------
  clock_synth_strobe u_clock_synth_strobe (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clock_sel(misc_clock_sel),
    .dot_select(nxt_st.pclk_mode[3:0]),
    .dot_written(dot_written),
    .clock_strobe_write(clock_strobe_write),
    .synth_code(synth_code)
  );
endmodule // ext_crtc_lock_config_regs

// >>> bench/host_bus_model.sv
// Host processor model for the index/data register port
`timescale 1ns/1ns
module host_bus_model (
  input wire logic clk_sys,
  output ext_crtc_pkg::host_req_t host_req,
  input wire logic [7:0] host_rdata,
  input wire logic host_rvalid
);
  import ext_crtc_pkg::*;
  initial host_req = '0;
  // One request a cycle, raised and dropped at falling edges
  task automatic put(input logic [2:0] k, input logic [7:0] d);
    @(negedge clk_sys);
    host_req = {k, d};
    @(negedge clk_sys);
    host_req = '0;
  endtask
  // Index goes out first, then the data unchanged, each as its own request
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    put(3'h4, i);
    put(3'h2, d);
  endtask
  task automatic rd(input logic [7:0] i, output logic [7:0] d);
    put(3'h4, i);
    put(3'h1, 8'h00);
    d = host_rvalid ? host_rdata : ~host_rdata;
  endtask
endmodule // host_bus_model

// >>> bench/ext_crtc_chk.sv
// Port assertions for the register bank
`timescale 1ns/1ns
module ext_crtc_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire ext_crtc_pkg::host_req_t host_req,
  input wire logic [7:0] host_rdata,
  input wire logic host_rvalid,
  input wire ext_crtc_pkg::std_wr_t std_wr,
  input wire logic monitor_id_pin0_i,
  input wire logic [1:0] misc_clock_sel,
  input wire logic clock_strobe_write,
  input wire logic zero_wait_out,
  input wire logic [1:0] read_wait_states,
  input wire logic mem16_select_out,
  input wire logic wide_bus_enable,
  input wire logic bus_grant_in
);
  import ext_crtc_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_read;
    host_req.data_rd;
  endsequence
  sequence s_sel_enter;
    misc_clock_sel == CLK_SEL_EXT && $past(misc_clock_sel) != CLK_SEL_EXT;
  endsequence
  a_read_answer: assert property (s_read |=> host_rvalid)
    else $error("read unanswered");
  a_rdata_hold: assert property (!host_rvalid |-> $stable(host_rdata))
    else $error("read data moved");
  a_fwd_cause: assert property (std_wr.wr |-> $past(host_req.data_wr))
    else $error("stray forward");
  a_strobe_sel: assert property (
    clock_strobe_write |-> $past(misc_clock_sel) == CLK_SEL_EXT)
    else $error("strobe without select");
  a_strobe_entry: assert property (s_sel_enter |=> clock_strobe_write)
    else $error("strobe missing");
  a_zero_wait: assert property (zero_wait_out |-> read_wait_states == 2'h0)
    else $error("zero wait with waits");
  a_mem16_wide: assert property (mem16_select_out |-> wide_bus_enable)
    else $error("wide select on narrow bus");
  a_grant_pin: assert property (bus_grant_in |-> !$past(monitor_id_pin0_i))
    else $error("grant without pin low");
endmodule // ext_crtc_chk

// >>> bench/ext_crtc_lock_config_regs_tb.sv
// Self-checking bench for the register bank
`timescale 1ns/1ns
module ext_crtc_lock_config_regs_tb;
  import ext_crtc_pkg::*;
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  logic [15:0] pixel_data_strap_pins = 16'h0000;
  logic [19:0] host_addr = 20'h0_0000;
  logic [1:0] misc_clock_sel = 2'h0;
  logic [7:0] h_char_count = 8'h00;
  logic grant_pull = 1'h0;
  host_req_t host_req;
  std_wr_t std_wr;
  logic [7:0] host_rdata, interlace_offset;
  logic [3:0] display_addr_hi, synth_code;
  logic [1:0] alt_refresh_count, decode_wait_states, read_wait_states;
  logic host_rvalid, monitor_id_pin0_i, monitor_id_pin0_o, monitor_id_pin0_oe;
  logic monitor_id_pin1_i, monitor_id_pin1_o, monitor_id_pin1_oe, rom_chip_select;
  logic setup_bit_is_bit4, zero_wait_out, mem16_select_out, wide_bus_enable;
  logic alt_refresh_enable, top_of_memory, enhanced_color_shift, transfer_cycle_pulse;
  logic interlace_active, enhanced_access_en, bus_grant_in, wait_state_control;
  logic write_posting_enable, clock_strobe_write;
  logic device_enable, local_access_tristate, local_access_ack_en, local_ready_en;
  logic [1:0] monitor_id;
  int bad_count = 0;
  int checks = 0;
  always #20 clk_sys = ~clk_sys;
  // Released pins float high on their pull-ups, except pin 0, which grant_pull drives low
  assign monitor_id_pin0_i = monitor_id_pin0_oe ? monitor_id_pin0_o : !grant_pull;
  assign monitor_id_pin1_i = monitor_id_pin1_oe ? monitor_id_pin1_o : 1'h1;
  ext_crtc_lock_config_regs ext_crtc_lock_config_regs_i (.dac_access(1'h0),
    .h_total_pos(8'h30), .dac_ctl_strobe_mode(1'h0), .strobe_read_req_n(1'h1),
    .bus_request_req_n(1'h1), .*);
  host_bus_model host_bus_model_i (.*);
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask
  task automatic w(input logic [7:0] i, input logic [7:0] d);
    host_bus_model_i.wr(i, d);
  endtask
  task automatic rchk(input logic [7:0] i, input logic [7:0] e);
    logic [7:0] d;
    host_bus_model_i.rd(i, d);
    chk8(d, e);
  endtask
  task automatic fwd(input logic [7:0] i, input logic [7:0] k);
    w(i, 8'h00);
    chk1(std_wr.wr, 1'h1);
    chk8(std_wr.keep_mask, k);
  endtask
  // The strobe may land in the cycle the write returns, so look there too
  task automatic strobe(input logic e);
    logic seen;
    seen = clock_strobe_write;
    repeat (4) begin
      @(negedge clk_sys);
      seen = seen | clock_strobe_write;
    end
    chk1(seen, e);
  endtask
  task automatic do_reset(input logic [15:0] s);
    @(negedge clk_sys);
    rst_n = 1'h0;
    pixel_data_strap_pins = s;
    misc_clock_sel = 2'h0;
    repeat (16) @(negedge clk_sys);
    rst_n = 1'h1;
  endtask
  task automatic t_reset();
    rchk(IDX_EXT_KEY, 8'h00);
    rchk(IDX_MISC_MEM, 8'h00);
    rchk(IDX_BUS_CFG, 8'h00);
    chk8({5'h00, wait_state_control, read_wait_states}, 8'h07);
    $display("reset test done");
  endtask
  task automatic t_keys();
    w(IDX_EXT_KEY, 8'h7b);
    w(IDX_MISC_MEM, 8'h9f);
    rchk(IDX_MISC_MEM, 8'h9f);
    chk8({4'h0, wide_bus_enable, alt_refresh_enable, alt_refresh_count}, 8'h0f);
    chk8({6'h00, top_of_memory, enhanced_color_shift}, 8'h03);
    w(IDX_EXT_KEY, 8'h7f);
    rchk(IDX_MISC_MEM, 8'h00);
    w(IDX_EXT_KEY, 8'h48);
    rchk(IDX_BUS_CFG, 8'h00);
    w(IDX_SYS_KEY, 8'hbf);
    rchk(IDX_BUS_CFG, 8'ha4);
    w(IDX_BUS_CFG, 8'h0b);
    chk8({wait_state_control, write_posting_enable, enhanced_access_en, 5'h00}, 8'h60);
    chk8({read_wait_states, decode_wait_states, zero_wait_out, mem16_select_out, 2'h0},
      8'h0c);
    grant_pull = 1'h1;
    repeat (2) @(negedge clk_sys);
    chk8({5'h00, monitor_id_pin1_oe, bus_grant_in, monitor_id_pin0_oe}, 8'h06);
    grant_pull = 1'h0;
    w(IDX_BUS_CFG, 8'hb0);
    chk8({read_wait_states, decode_wait_states, zero_wait_out, 1'h0, monitor_id},
      8'he3);
    $display("key test done");
  endtask
  task automatic t_straps();
    rchk(IDX_STRAP_LO, 8'h0b);
    rchk(IDX_STRAP_HI, 8'h19);
    chk1(setup_bit_is_bit4, 1'h1);
    host_addr = 20'hc_6000;
    w(IDX_TIMING_LOCK, 8'h0f);
    chk1(rom_chip_select, 1'h1);
    @(negedge clk_sys);
    chk8({4'h0, display_addr_hi}, 8'h00);
    rchk(IDX_TIMING_LOCK, 8'h0f);
    $display("strap test done");
  endtask
  task automatic t_locks();
    w(IDX_TIMING_LOCK, 8'h20);
    fwd(8'h00, 8'hff);
    fwd(8'h17, 8'h04);
    fwd(8'h06, 8'h00);
    w(IDX_TIMING_LOCK, 8'h10);
    fwd(8'h07, 8'had);
    fwd(8'h09, 8'h20);
    fwd(8'h11, 8'h0f);
    fwd(8'h05, 8'h00);
    w(IDX_TIMING_LOCK, 8'h00);
    w(8'h11, 8'h80);
    fwd(8'h03, 8'hff);
    fwd(8'h17, 8'h00);
    w(8'h11, 8'h00);
    $display("lock test done");
  endtask
  task automatic t_clock();
    w(IDX_IL_OFS, 8'h5a);
    w(IDX_PCLK_MODE, 8'h25);
    strobe(1'h0);
    chk8(interlace_active ? interlace_offset : 8'h00, 8'h5a);
    misc_clock_sel = 2'h3;
    strobe(1'h1);
    chk8({4'h0, synth_code}, 8'h05);
    w(IDX_PCLK_MODE, 8'h26);
    strobe(1'h1);
    chk8({4'h0, synth_code}, 8'h06);
    misc_clock_sel = 2'h0;
    w(IDX_XFER_POS, 8'h20);
    h_char_count = 8'h20;
    @(negedge clk_sys);
    chk1(transfer_cycle_pulse, 1'h0);
    h_char_count = 8'h30;
    @(negedge clk_sys);
    chk1(transfer_cycle_pulse, 1'h1);
    h_char_count = 8'h00;
    w(IDX_BKWD3, 8'h10);
    h_char_count = 8'h20;
    @(negedge clk_sys);
    chk1(transfer_cycle_pulse, 1'h1);
    h_char_count = 8'h00;
    $display("clock test done");
  endtask
  task automatic t_rom();
    @(negedge clk_sys);
    chk1(rom_chip_select, 1'h0);
    host_addr = 20'hc_0000;
    @(negedge clk_sys);
    chk8({2'h0, device_enable, local_access_tristate, local_access_ack_en, local_ready_en,
      rom_chip_select, setup_bit_is_bit4}, 8'h2e);
    $display("rom test done");
  endtask
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    print_verdict();
  end
  initial begin
    do_reset(16'h190b);
    t_reset();
    t_keys();
    t_straps();
    t_locks();
    t_clock();
    do_reset(16'h0003);
    t_reset();
    t_rom();
    print_verdict();
  end
endmodule // ext_crtc_lock_config_regs_tb
bind ext_crtc_lock_config_regs ext_crtc_chk ext_crtc_chk_i (.*);
